// *** core/host_port_consts.svh ***
// host port constants: register offsets, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define MEM_DEPTH        256
`define REG_SPACE_TOP    8'h3F
`define BUF_BASE         8'h40
`define OFF_CTRL         8'h05
`define OFF_IRQ_EN       8'h06
`define OFF_IRQ_STATUS   8'h0D
`define OFF_EP3A_BASE    8'h31
`define OFF_DMA_CNT_LO   8'h35
`define OFF_DMA_CNT_HI   8'h36
`define CTRL_DMA_EN_BIT  1
`define CTRL_DMA_DIR_BIT 2
`define CTRL_FORCE_K_BIT 5
`define CTRL_MULT_EN_BIT 6
`define CTRL_LOW_SPD_BIT 7
`define RST_BYTE         8'h00
`endif

// *** core/host_port_pkg.sv ***
// host port types: strobe bundle and access states
// assumes the constants header supplies numbers
package host_port_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic selLow;
    logic wrLow;
    logic rdLow;
    logic addrSel;
    logic ackLow;
  } pins_t;
  typedef enum logic [1:0] {IDLE, ACTIVE} cyc_t;
endpackage

// *** core/pin_sync.sv ***
// three-stage synchroniser for a bundle of pin inputs
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] s1R;
  logic [W-1:0] s2R;
  logic [W-1:0] s3R;
  // ===================================
  // sync chain; pinOut moves when stage 2 and 3 agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1R    <= {W{1'b1}};
      s2R    <= {W{1'b1}};
      s3R    <= {W{1'b1}};
      pinOut <= {W{1'b1}};
    end else begin
      s1R <= pinIn;
      s2R <= s1R;
      s3R <= s2R;
      for (int i = 0; i < W; i++) begin
        if (s2R[i] == s3R[i]) begin
          pinOut[i] <= s3R[i];
        end
      end
    end
  end
endmodule

// *** core/usb_slave_host_port.sv ***
// host port of a usb slave controller: indexed memory, dma, irq, clock ctl
// assumes pins async to sys_clk; serial engine sits outside on evt ports
// Functional notes
// - An address write with select low loads the pointer, data cycles go there.
// - A cycle ends when write or read strobe or device select goes inactive.
// - Memory is 256 bytes, low 64 registers and upper 192 data buffer.
// - Every host data cycle advances the address pointer by one.
// - Reads auto-increment exactly like writes.
// - One interrupt output rises on any enabled event shown in status.
// - Writing the interrupt status register clears pending bits.
// - DMA uses a request out, an acknowledge in, and the write or read strobe.
// - A count register sets the DMA block; requests run until it is done or a move at address FF ends it.
// - The serial engine reaches buffer memory through its own port.
// - The 4x multiplier runs only with the register bit and pin high.
// - The force bit drives a K state on the bus for remote wakeup.
// - A speed bit selects full or low speed for the serial engine.
// - DMA serves only the endpoint 3 buffer.
`timescale 1ns/1ps
`include "host_port_consts.svh"
module usb_slave_host_port
  import host_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       device_select_low,
  input  wire logic       write_strobe_low,
  input  wire logic       read_strobe_low,
  input  wire logic       addr_data_select,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  output logic            irq_out,
  output logic            dma_request_low,
  input  wire logic       dma_ack_low,
  input  wire logic       clk_mult_select,
  output logic            multEnable,
  output logic            forceK,
  output logic            lowSpeed,
  input  wire logic [7:0] usbEvent,
  input  wire logic       engWe,
  input  wire logic       engRe,
  input  wire logic [7:0] engAddr,
  input  wire logic [7:0] engWData,
  output logic      [7:0] engRData
);
  // ===================================
  // pin synchronisation
  pins_t pinsRaw;
  pins_t pins;
  logic [7:0] dataS0R;
  logic [7:0] dataS1R;
  logic [7:0] dataS2R;
  assign pinsRaw = '{selLow: device_select_low, wrLow: write_strobe_low,
                     rdLow: read_strobe_low, addrSel: addr_data_select,
                     ackLow: dma_ack_low};
  pin_sync #(.W(5)) uSync (
    .sys_clk(sys_clk),
    .rst    (rst),
    .pinIn  (pinsRaw),
    .pinOut (pins)
  );
  // data bus passes three stages; it settles before the strobes do,
  // so no agree test is needed, the strobe path is the slower one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataS0R <= `RST_BYTE;
      dataS1R <= `RST_BYTE;
      dataS2R <= `RST_BYTE;
    end else begin
      dataS0R <= dataIn;
      dataS1R <= dataS0R;
      dataS2R <= dataS1R;
    end
  end

  // ===================================
  // cycle decode
  function automatic logic inc8Wrap(input logic [7:0] a);
    return a == 8'hFF;
  endfunction
  cyc_t cycR, cycNxt;
  logic wrOn, rdOn, dmaOn, cpuOn, stbOn, cycStart;
  logic addrWr, dataWr, dataRd, dmaWr, dmaRd;
  logic dmaActR, dmaActNxt;
  assign dmaOn    = !pins.ackLow && dmaActR;
  assign cpuOn    = !pins.selLow;
  assign wrOn     = !pins.wrLow;
  assign rdOn     = !pins.rdLow;
  assign stbOn    = (cpuOn || dmaOn) && (wrOn || rdOn);
  assign cycStart = (cycR == IDLE) && stbOn;
  assign cycNxt   = stbOn ? ACTIVE : IDLE;
  // select line splits address from data
  assign addrWr = cycStart && cpuOn && !dmaOn && wrOn && !pins.addrSel;
  assign dataWr = cycStart && cpuOn && !dmaOn && wrOn && pins.addrSel;
  assign dataRd = cycStart && cpuOn && !dmaOn && rdOn && pins.addrSel;
  // dma move qualified by write or read strobe
  assign dmaWr  = cycStart && dmaOn && wrOn;
  assign dmaRd  = cycStart && dmaOn && rdOn;

  // ===================================
  // storage: 256 bytes, registers live in the same array
  // registers low, buffer high
  logic [7:0] memR [`MEM_DEPTH];
  logic [7:0] ptrR, ptrNxt;
  logic [7:0] dmaPtrR, dmaPtrNxt;
  logic [15:0] dmaLeftR, dmaLeftNxt;
  logic [7:0] ctrl, irqEn, status;
  logic [7:0] wrAddr, wrData;
  logic       memWe;
  logic       statusWr;
  logic       dmaGo;
  assign ctrl   = memR[`OFF_CTRL];
  assign irqEn  = memR[`OFF_IRQ_EN];
  assign status = memR[`OFF_IRQ_STATUS];
  assign memWe  = dataWr || dmaWr;
  assign wrAddr = dmaWr ? dmaPtrR : ptrR;
  assign wrData = dataS2R;
  assign statusWr = dataWr && (ptrR == `OFF_IRQ_STATUS);
  assign ptrNxt = addrWr ? dataS2R
                : (dataWr || dataRd) ? ptrR + 8'h01 : ptrR;
  // dma start when enable bit written with nonzero count
  assign dmaGo = dataWr && (ptrR == `OFF_CTRL)
                 && dataS2R[`CTRL_DMA_EN_BIT]
                 && ({memR[`OFF_DMA_CNT_HI], memR[`OFF_DMA_CNT_LO]} != 0);
  // dma pointer starts at endpoint 3 base
  assign dmaPtrNxt = dmaGo ? memR[`OFF_EP3A_BASE]
                   : (dmaWr || dmaRd) ? dmaPtrR + 8'h01 : dmaPtrR;
  assign dmaLeftNxt = dmaGo ? {memR[`OFF_DMA_CNT_HI], memR[`OFF_DMA_CNT_LO]}
                    : (dmaWr || dmaRd) ? dmaLeftR - 16'h0001 : dmaLeftR;
  assign dmaActNxt = dmaGo ? 1'b1
                   : ((dmaWr || dmaRd) && dmaLeftR == 16'h0001) ? 1'b0
                   : (dmaActR && inc8Wrap(dmaPtrR) && (dmaWr || dmaRd))
                     ? 1'b0 : dmaActR;

  // cycle and pointer state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cycR     <= IDLE;
      ptrR     <= `RST_BYTE;
      dmaPtrR  <= `RST_BYTE;
      dmaLeftR <= 16'h0000;
      dmaActR  <= 1'b0;
    end else begin
      cycR     <= cycNxt;
      ptrR     <= ptrNxt;
      dmaPtrR  <= dmaPtrNxt;
      dmaLeftR <= dmaLeftNxt;
      dmaActR  <= dmaActNxt;
    end
  end

  // ===================================
  // memory write: host, dma, serial engine, and event capture
  // host wins over engine on a same-cycle collision; the engine write is dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MEM_DEPTH; i++) begin
        memR[i] <= `RST_BYTE;
      end
    end else begin
      if (engWe && !memWe) begin
        memR[engAddr] <= engWData;
      end
      if (memWe && !statusWr) begin
        memR[wrAddr] <= wrData;
      end
      // write clears named bits; new events win over the clear
      memR[`OFF_IRQ_STATUS] <= (statusWr ? (status & ~dataS2R) : status)
                               | usbEvent;
    end
  end

  // ===================================
  // read path, registered on the strobe edge
  logic [7:0] rdAddr;
  assign rdAddr = dmaRd ? dmaPtrR : ptrR;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataOut  <= `RST_BYTE;
      engRData <= `RST_BYTE;
    end else begin
      if (dataRd || dmaRd) begin
        dataOut <= memR[rdAddr];
      end
      if (engRe) begin
        engRData <= memR[engAddr];
      end
    end
  end
  // drive only while a read cycle is live
  assign dataOe = (cycR == ACTIVE) && rdOn && (cpuOn || dmaOn)
                  && (pins.addrSel || dmaOn);

  // ===================================
  // outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_out         <= 1'b0;
      dma_request_low <= 1'b1;
      multEnable      <= 1'b0;
      forceK          <= 1'b0;
      lowSpeed        <= 1'b0;
    end else begin
      irq_out         <= |(status & irqEn);
      // request held until block is moved or a move at address FF ends it
      dma_request_low <= !dmaActNxt;
      multEnable      <= ctrl[`CTRL_MULT_EN_BIT] && clk_mult_select;
      forceK          <= ctrl[`CTRL_FORCE_K_BIT];
      lowSpeed        <= ctrl[`CTRL_LOW_SPD_BIT];
    end
  end
endmodule

// *** test/usb_host_port_sva.sv ***
// checker: timing relations at the host port pins
// assumes one sys_clk domain; attached by the bind at the foot
`timescale 1ns/1ps
module usb_host_port_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       write_strobe_low,
  input wire logic       read_strobe_low,
  input wire logic [7:0] dataOut,
  input wire logic       dataOe,
  input wire logic       irq_out,
  input wire logic       dma_request_low,
  input wire logic       clk_mult_select,
  input wire logic       multEnable,
  input wire logic       forceK,
  input wire logic       lowSpeed,
  input wire logic       engRe,
  input wire logic [7:0] engRData
);
  // ==========================================
  // strobe ages, saturating so they never wrap
  logic [3:0] wrAge_r, rdAge_r;
  wire  [3:0] wrAge_nxt = !write_strobe_low ? 4'h0
                        : wrAge_r + {3'h0, ~&wrAge_r};
  wire  [3:0] rdAge_nxt = !read_strobe_low ? 4'h0
                        : rdAge_r + {3'h0, ~&rdAge_r};
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) {wrAge_r, rdAge_r} <= 8'hFF;
    else {wrAge_r, rdAge_r} <= {wrAge_nxt, rdAge_nxt};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // outputs idle after reset, then move only shortly after their cause
  chk_reset_idle: assert property (
    $fell(rst) |-> dma_request_low && !forceK && !irq_out)
    else $error("outputs not idle after reset");
  chk_oe_on_read: assert property (
    dataOe |-> rdAge_r < 4'h8) else $error("bus driven without read");
  chk_rdata_moves: assert property (
    !$stable(dataOut) |-> rdAge_r < 4'h8) else $error("read data moved");
  chk_irq_clear: assert property (
    $fell(irq_out) |-> wrAge_r < 4'hC) else $error("irq fell unasked");
  chk_dma_on_write: assert property (
    !$stable(dma_request_low) |-> wrAge_r < 4'hC)
    else $error("dma request moved without a write");
  chk_ctrl_on_write: assert property (
    !$stable({forceK, lowSpeed}) |-> wrAge_r < 4'hC)
    else $error("control outputs moved without a write");
  chk_mult_gate: assert property (
    !clk_mult_select [*8] |-> !multEnable) else $error("mult without pin");
  chk_eng_read: assert property (
    !$stable(engRData) |-> $past(engRe)) else $error("engine data moved");
endmodule
bind usb_slave_host_port usb_host_port_sva chk_u (.sys_clk, .rst,
  .write_strobe_low, .read_strobe_low, .dataOut, .dataOe, .irq_out,
  .dma_request_low, .clk_mult_select, .multEnable, .forceK, .lowSpeed,
  .engRe, .engRData);

// *** test/host_cpu_model.sv ***
// processor model: strobed bus cycles on the host port pins
// assumes sys_clk from the bench; no pull-ups on the data lines
`timescale 1ns/1ps
module host_cpu_model
  import host_port_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire byte_t dataOut,
  output logic       device_select_low,
  output logic       write_strobe_low,
  output logic       read_strobe_low,
  output logic       addr_data_select,
  output logic       dma_ack_low,
  output byte_t      dataIn
);
  initial {device_select_low, write_strobe_low, read_strobe_low,
           addr_data_select, dma_ack_low, dataIn} = '1;
  // ==========================================
  // one access; lo is the strobe length in cycles
  // address or data, dma by ack
  task automatic cyc(input logic a0, wr, dma, input byte_t d,
                     input int lo, output byte_t q);
    @(posedge sys_clk);
    addr_data_select <= a0;
    dataIn <= wr ? d : ~dataIn;
    device_select_low <= dma;
    dma_ack_low <= !dma;
    write_strobe_low <= !wr;
    read_strobe_low <= wr;
    repeat (lo) @(posedge sys_clk);
    q = dataOut;
    {device_select_low, write_strobe_low, read_strobe_low} <= 3'h7;
    dma_ack_low <= 1'b1;
    // released bus shows the inverse, not a stale value
    dataIn <= ~dataIn;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// *** test/tb_usb_slave_host_port.sv ***
// bench for the host port: memory, control, irq, dma and engine port
// assumes the processor model drives the pins; events come from here
`timescale 1ns/1ps
module tb_usb_slave_host_port;
  import host_port_pkg::*;
  logic  sys_clk = 1'b0, rst = 1'b1, clk_mult_select = 1'b0;
  logic  engWe = 1'b0, engRe = 1'b0, dataOe, irq_out, dma_request_low;
  logic  device_select_low, write_strobe_low, read_strobe_low;
  logic  addr_data_select, dma_ack_low, multEnable, forceK, lowSpeed;
  byte_t usbEvent = 8'h00, engAddr = 8'h00, engWData = 8'h00;
  byte_t dataIn, dataOut, engRData, q;
  byte_t pat[3] = '{8'h55, 8'hAA, 8'hBB};
  int    errors = 0, n_tests = 0;
  logic  oeSeen = 1'b0;
  always #50 sys_clk = ~sys_clk;
  // remember any cycle in which the design drove the data bus
  always @(posedge sys_clk) if (dataOe) oeSeen <= 1'b1;
  usb_slave_host_port dut_u (.sys_clk, .rst, .device_select_low,
    .write_strobe_low, .read_strobe_low, .addr_data_select, .dataIn,
    .dataOut, .dataOe, .irq_out, .dma_request_low, .dma_ack_low,
    .clk_mult_select, .multEnable, .forceK, .lowSpeed, .usbEvent, .engWe,
    .engRe, .engAddr, .engWData, .engRData);
  host_cpu_model cpu_u (.sys_clk, .dataOut, .device_select_low,
    .write_strobe_low, .read_strobe_low, .addr_data_select, .dma_ack_low,
    .dataIn);
  // ==========================================
  // shared access and compare tasks
  task automatic chk(input byte_t seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic a0, wrt, input byte_t d);
    cpu_u.cyc(a0, wrt, 1'b0, d, 8, q);
  endtask
  task automatic put(input byte_t a, d);
    acc(1'b0, 1'b1, a);
    acc(1'b1, 1'b1, d);
  endtask
  task automatic print_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well beyond the ~520 cycles the tests take
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  // ==========================================
  // test sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({7'h00, dma_request_low}, 8'h01);
    acc(1'b0, 1'b1, 8'hFD);
    foreach (pat[i]) acc(1'b1, 1'b1, pat[i]);
    acc(1'b0, 1'b1, 8'hFD);
    acc(1'b0, 1'b0, 8'h00);
    chk({7'h00, oeSeen}, 8'h00);
    foreach (pat[i]) begin
      acc(1'b1, 1'b0, 8'h00);
      chk(q, pat[i]);
    end
    chk({7'h00, oeSeen}, 8'h01);
    clk_mult_select <= 1'b1;
    put(8'h05, 8'hE0);
    chk({5'h00, forceK, lowSpeed, multEnable}, 8'h07);
    clk_mult_select <= 1'b0;
    put(8'h05, 8'h00);
    chk({5'h00, forceK, lowSpeed, multEnable}, 8'h00);
    put(8'h06, 8'h01);
    // frame event pulse; the processor times gaps itself
    usbEvent <= 8'h03;
    @(posedge sys_clk);
    usbEvent <= 8'h00;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, irq_out}, 8'h01);
    put(8'h0D, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    acc(1'b0, 1'b1, 8'h0D);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    put(8'h31, 8'h80);
    put(8'h35, 8'h02);
    acc(1'b1, 1'b1, 8'h00);
    put(8'h05, 8'h02);
    chk({7'h00, dma_request_low}, 8'h00);
    cpu_u.cyc(1'b1, 1'b1, 1'b1, 8'hC1, 12, q);
    chk({7'h00, dma_request_low}, 8'h00);
    cpu_u.cyc(1'b1, 1'b1, 1'b1, 8'hC2, 8, q);
    chk({7'h00, dma_request_low}, 8'h01);
    acc(1'b0, 1'b1, 8'h80);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'hC1);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'hC2);
    {engWe, engAddr, engWData} <= {1'b1, 8'h90, 8'h3C};
    @(posedge sys_clk);
    {engWe, engRe, engAddr} <= {1'b0, 1'b1, 8'h81};
    @(posedge sys_clk);
    engRe <= 1'b0;
    @(posedge sys_clk);
    chk(engRData, 8'hC2);
    acc(1'b0, 1'b1, 8'h90);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h3C);
    print_verdict();
  end
endmodule
